// *** verilog/scc_pkg.sv ***
// Package with register map, field positions and reset values of the card contact block
package scc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] SCC_IDX_CONTACT = 8'hAC;
    localparam logic [7:0] SCC_IDX_STATUS = 8'hAD;
    localparam logic [7:0] SCC_IDX_CTRL = 8'hAE;
    localparam logic [7:0] SCC_IDX_TXBUF = 8'hAF;
    localparam logic [7:0] SCC_IDX_IRQ_STAT = 8'hB0;
    localparam logic [7:0] SCC_IDX_IRQ_MASK = 8'hB1;
    localparam int SCC_AW = 10;
    // Contact register fields
    localparam int SCC_CON_CLKSEL = 7;
    localparam int SCC_CON_RSVD = 6;
    localparam int SCC_CON_C8 = 5;
    localparam int SCC_CON_C4 = 4;
    localparam int SCC_CON_IO = 3;
    localparam int SCC_CON_SWCLK = 2;
    localparam int SCC_CON_RST = 1;
    localparam int SCC_CON_VCC = 0;
    // Interface status register fields
    localparam int SCC_ST_TBE = 7;
    localparam int SCC_ST_CARD_INSERTED_STATUS = 6;
    localparam int SCC_ST_OVF = 5;
    localparam int SCC_ST_VOK = 4;
    // Interface control register fields
    localparam int SCC_CTL_SWRST = 7;
    localparam int SCC_CTL_VSEL_LO = 4;
    localparam int SCC_CTL_UART = 3;
    // Interrupt status / mask fields
    localparam int SCC_IRQ_TBE = 0;
    localparam int SCC_IRQ_VERR = 1;
    localparam int SCC_IRQ_OVF = 2;
    localparam int SCC_IRQ_W = 3;
    // Reset values
    localparam logic [7:0] SCC_CONTACT_RST = 8'h00;
    localparam logic [7:0] SCC_CTRL_RST = 8'h00;
    localparam logic SCC_TBE_RST = 1'b1;
    localparam logic [SCC_IRQ_W-1:0] SCC_IRQ_RST = 3'h0;
endpackage

// *** verilog/scc_contact.sv ***
// Smart card contact control block with APB register access
// How it works
// - clock select bit 7 picks software level (0) or hardware card clock (1).
// - clock source switch happens only while pin is low, and a new hardware source low too.
// - reserved contact bit 6 is writable, has no effect, reads as zero.
// - C8 bit drives C8 pin low or high; high is released, pin readable.
// - C4 bit drives C4 pin low or high; high is released, pin readable.
// - with UART off, card I/O bit drives pin; write one then read pin.
// - with clock select 0 the software clock level bit drives the clock pin.
// - card reset bit drives card reset pin low or high.
// - supply bit zero powers card off; other contact bits then ignored.
// - contact register resets to all zeros.
// - transmit buffer empty sets when buffer moves into shift register.
// - writing the card UART data buffer clears transmit buffer empty.
// - UART select routes card I/O pin to I/O bit (0) or UART (1).
// - voltage correct status follows the supply-in-range input.
// - interface software reset bit deactivates interface; clearing reactivates.
//
// Local design decision: the APB slave port.

// Limitation: contact writes are not gated on voltage status; software owns that check
// Trade-off: hardware card clock is sampled on clk_i, so its edges land on clk_i edges
module scc_contact
    import scc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [SCC_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic card_hw_clock_i,
    input wire logic uart_tx_i,
    input wire logic tx_buf_moved_i,
    input wire logic card_present_i,
    input wire logic card_voltage_ok_i,
    input wire logic card_overcurrent_i,
    input wire logic card_io_pin_i,
    input wire logic aux_pin_four_i,
    input wire logic aux_pin_eight_i,
    output logic card_io_pin_o,
    output logic card_io_pin_oe_o,
    output logic aux_pin_four_o,
    output logic aux_pin_four_oe_o,
    output logic aux_pin_eight_o,
    output logic aux_pin_eight_oe_o,
    output logic card_clock_pin_o,
    output logic card_reset_pin_o,
    output logic card_supply_en_o,
    output logic [1:0] card_voltage_select_o,
    output logic [7:0] tx_data_o,
    output logic tx_data_valid_o,
    output logic irq_o
);
    // Whole block state in one register; reset and update stay in one place
    typedef struct packed {
        // Software-visible registers
        logic [7:0] contact;
        logic [7:0] ctrl;
        logic tbe;
        logic [7:0] txdata;
        logic txvalid;
        logic [SCC_IRQ_W-1:0] ist;
        logic [SCC_IRQ_W-1:0] imask;
        // Previous levels for event edges
        logic vok_prev;
        logic ovf_prev;
        // Card pin drivers
        logic clk_sel;
        logic clk_pin;
        logic io_o;
        logic io_oe;
        logic c4_o;
        logic c4_oe;
        logic c8_o;
        logic c8_oe;
        logic rst_pin;
        logic vcc;
        // Interrupt line and bus answer
        logic irq;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } scc_state_t;

    // Current and next copy of the state
    scc_state_t s_q;
    scc_state_t s_d;

    // Decode and helper nets
    logic acc;
    logic wr;
    logic [7:0] idx;
    logic active;
    logic want_hw;
    logic new_src;
    logic [7:0] rd;
    logic [7:0] st;
    logic hit;
    logic old_hi;
    logic [2:0] pin_in;
    logic [2:0] pin_rb;

    // Word index from byte address; low two bits must be zero
    assign idx = paddr_i[SCC_AW-1:2];
    // Access completes in the cycle that shows ready
    assign acc = psel_i & penable_i & s_q.pready;
    assign wr = acc & pwrite_i;
    // Card is live only with supply bit set and interface out of reset
    assign active = s_q.contact[SCC_CON_VCC] & ~s_q.ctrl[SCC_CTL_SWRST];

    // Status view: tbe, presence, overcurrent, voltage ok; UART bits live elsewhere
    assign st = {s_q.tbe, card_present_i, card_overcurrent_i, card_voltage_ok_i,
                 4'h0};

    // Pin-backed contact bits: stored bit AND pin level, one slice per pin
    // A released pin shows the card's level, so a card pulling low reads zero
    assign pin_in = {aux_pin_eight_i, aux_pin_four_i, card_io_pin_i};
    for (genvar g = 0; g < 3; g++) begin : g_pin_rb
        assign pin_rb[g] = s_q.contact[SCC_CON_IO+g] & pin_in[g];
    end


    // Read mux; pin-backed contact bits return stored bit AND pin level
    always_comb begin
        rd = 8'h00;
        hit = 1'b1;
        // One byte register per word
        case (idx)
            SCC_IDX_CONTACT: begin
                rd = s_q.contact;
                rd[SCC_CON_RSVD] = 1'b0;
                rd[SCC_CON_C8] = pin_rb[2];
                rd[SCC_CON_C4] = pin_rb[1];
                rd[SCC_CON_IO] = pin_rb[0];
            end
            SCC_IDX_STATUS: rd = st;
            SCC_IDX_CTRL: rd = s_q.ctrl;
            SCC_IDX_TXBUF: rd = s_q.txdata;
            SCC_IDX_IRQ_STAT: rd = {5'h00, s_q.ist};
            SCC_IDX_IRQ_MASK: rd = {5'h00, s_q.imask};
            default: hit = 1'b0;
        endcase
        // Misaligned access: refuse and return zero
        if (paddr_i[1:0] != 2'b00) begin
            hit = 1'b0;
            rd = 8'h00;
        end
    end

    // Next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        // One wait state: pready rises in the second access cycle, then drops
        s_d.pready = psel_i & penable_i & ~s_q.pready;
        s_d.prdata = 32'h0000_0000;
        s_d.pslverr = 1'b0;
        s_d.txvalid = 1'b0;
        if (acc) begin
            s_d.pready = 1'b0;
        end

        // Read data captured in the first access cycle, shown with ready
        if (psel_i & penable_i & ~s_q.pready) begin
            s_d.prdata = pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd};
            s_d.pslverr = ~hit;
        end

        // Register writes take effect only at the completing edge
        if (wr & hit) begin
            case (idx)
                SCC_IDX_CONTACT: s_d.contact = pwdata_i[7:0];
                SCC_IDX_CTRL: s_d.ctrl = pwdata_i[7:0];
                // Data buffer write hands a byte to the UART and marks it full
                SCC_IDX_TXBUF: begin
                    s_d.txdata = pwdata_i[7:0];
                    s_d.txvalid = 1'b1;
                    s_d.tbe = 1'b0;
                end
                // Write one to clear; zeros leave bits alone
                SCC_IDX_IRQ_STAT: s_d.ist = s_q.ist & ~pwdata_i[SCC_IRQ_W-1:0];
                SCC_IDX_IRQ_MASK: s_d.imask = pwdata_i[SCC_IRQ_W-1:0];
                default: s_d.contact = s_q.contact;
            endcase
        end

        // Hardware set after clear: an event in the clearing cycle survives
        if (tx_buf_moved_i) begin
            s_d.tbe = 1'b1;
        end

        // Previous levels for the voltage and overcurrent edge detectors
        s_d.vok_prev = card_voltage_ok_i;
        s_d.ovf_prev = card_overcurrent_i;

        // Sticky interrupt causes; a set beats a clear in the same cycle
        if (tx_buf_moved_i) begin
            s_d.ist[SCC_IRQ_TBE] = 1'b1;
        end
        if (s_q.vok_prev & ~card_voltage_ok_i) begin
            s_d.ist[SCC_IRQ_VERR] = 1'b1;
        end
        if (~s_q.ovf_prev & card_overcurrent_i) begin
            s_d.ist[SCC_IRQ_OVF] = 1'b1;
        end

        // Software reset of the interface deactivates the contacts
        if (s_q.ctrl[SCC_CTL_SWRST]) begin
            s_d.contact = SCC_CONTACT_RST;
            s_d.tbe = SCC_TBE_RST;
        end

        // Card clock: switch source only at a low phase so no runt can appear
        // Old hardware source keeps the pin until its own fall; a software
        // level is static, so its high may end at once
        want_hw = s_q.contact[SCC_CON_CLKSEL];
        new_src = want_hw ? card_hw_clock_i : s_q.contact[SCC_CON_SWCLK];
        old_hi = s_q.clk_sel & card_hw_clock_i;
        if (s_q.clk_sel == want_hw) begin
            s_d.clk_pin = new_src;
        end else if (~s_q.clk_pin & ~(want_hw & new_src)) begin
            // Pin low: hand over; a new hardware source must be low as well
            s_d.clk_sel = want_hw;
            s_d.clk_pin = 1'b0;
        end else begin
            // Until the handover the pin may fall but never rise
            s_d.clk_pin = s_q.clk_pin & old_hi;
        end

        // Pseudo-bidirectional contacts: drive low, release for high
        s_d.c8_o = s_q.contact[SCC_CON_C8];
        s_d.c8_oe = ~s_q.contact[SCC_CON_C8];
        s_d.c4_o = s_q.contact[SCC_CON_C4];
        s_d.c4_oe = ~s_q.contact[SCC_CON_C4];
        // Card I/O: UART line or software bit, same release-for-high scheme
        if (s_q.ctrl[SCC_CTL_UART]) begin
            s_d.io_o = uart_tx_i;
            s_d.io_oe = ~uart_tx_i;
        end else begin
            s_d.io_o = s_q.contact[SCC_CON_IO];
            s_d.io_oe = ~s_q.contact[SCC_CON_IO];
        end
        // Reset contact and supply enable follow their bits
        s_d.rst_pin = s_q.contact[SCC_CON_RST];
        s_d.vcc = active;

        // Powered-off card: every contact held low, register bits ignored
        if (~active) begin
            s_d.clk_pin = 1'b0;
            s_d.clk_sel = 1'b0;
            s_d.c8_o = 1'b0;
            s_d.c8_oe = 1'b1;
            s_d.c4_o = 1'b0;
            s_d.c4_oe = 1'b1;
            s_d.io_o = 1'b0;
            s_d.io_oe = 1'b1;
            s_d.rst_pin = 1'b0;
        end

        // Interrupt from the next state, so it rises with its status bit
        s_d.irq = |(s_d.ist & s_d.imask);
    end

    // Single state register; reset values are constants only
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
            s_q.contact <= SCC_CONTACT_RST;
            s_q.ctrl <= SCC_CTRL_RST;
            s_q.tbe <= SCC_TBE_RST;
            s_q.ist <= SCC_IRQ_RST;
            s_q.imask <= SCC_IRQ_RST;
            // Pins driven low until software powers the card
            s_q.c8_oe <= 1'b1;
            s_q.c4_oe <= 1'b1;
            s_q.io_oe <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state flops
    assign prdata_o = s_q.prdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign card_io_pin_o = s_q.io_o;
    assign card_io_pin_oe_o = s_q.io_oe;
    assign aux_pin_four_o = s_q.c4_o;
    assign aux_pin_four_oe_o = s_q.c4_oe;
    assign aux_pin_eight_o = s_q.c8_o;
    assign aux_pin_eight_oe_o = s_q.c8_oe;
    assign card_clock_pin_o = s_q.clk_pin;
    assign card_reset_pin_o = s_q.rst_pin;
    assign card_supply_en_o = s_q.vcc;
    // Voltage choice goes straight to the supply converter
    assign card_voltage_select_o = s_q.ctrl[SCC_CTL_VSEL_LO+1:SCC_CTL_VSEL_LO];
    assign tx_data_o = s_q.txdata;
    assign tx_data_valid_o = s_q.txvalid;
    assign irq_o = s_q.irq;
endmodule

// *** bench/scc_contact_assertions.sv ***
// Port-level checker for the card contact block
module scc_contact_assertions (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic card_io_pin_o,
    input wire logic card_io_pin_oe_o,
    input wire logic aux_pin_four_o,
    input wire logic aux_pin_four_oe_o,
    input wire logic aux_pin_eight_o,
    input wire logic aux_pin_eight_oe_o,
    input wire logic card_clock_pin_o,
    input wire logic card_reset_pin_o,
    input wire logic card_supply_en_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Bus answer timing and shape
    a_ready_after_access: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no ready one cycle into access");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready stood too long");
    a_error_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_read_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("upper read bits set");
    // Driven I/O, C4 and C8 contacts only ever pull low
    a_io_drive_low: assert property (card_io_pin_oe_o |-> !card_io_pin_o)
        else $error("card io driven high");
    a_four_drive_low: assert property (aux_pin_four_oe_o |-> !aux_pin_four_o)
        else $error("aux four driven high");
    a_eight_drive_low: assert property (aux_pin_eight_oe_o |-> !aux_pin_eight_o)
        else $error("aux eight driven high");
    // Unpowered card sees every contact low
    a_off_pins_low: assert property (!card_supply_en_o |-> !card_clock_pin_o && !card_reset_pin_o
        && card_io_pin_oe_o && aux_pin_four_oe_o && aux_pin_eight_oe_o)
        else $error("contact active while unpowered");
endmodule
bind scc_contact scc_contact_assertions chk (.*);

// *** bench/scc_card_model.sv ***
// Card side of the contacts: pull-ups and a card that may hold I/O low
module scc_card_model (
    input wire logic card_io_pin_o,
    input wire logic card_io_pin_oe_o,
    input wire logic aux_pin_four_o,
    input wire logic aux_pin_four_oe_o,
    input wire logic aux_pin_eight_o,
    input wire logic aux_pin_eight_oe_o,
    input wire logic pull_low,
    output logic card_io_pin_i,
    output logic aux_pin_four_i,
    output logic aux_pin_eight_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released lines rise through the pull-up; card may sink I/O
    assign card_io_pin_i = (card_io_pin_oe_o ? card_io_pin_o : 1'b1) & ~pull_low;
    assign aux_pin_four_i = aux_pin_four_oe_o ? aux_pin_four_o : 1'b1;
    assign aux_pin_eight_i = aux_pin_eight_oe_o ? aux_pin_eight_o : 1'b1;
endmodule

// *** bench/scc_contact_tb.sv ***
// Register-level bench for the card contact block
module scc_contact_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scc_pkg::*;
    logic clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, pull_low = 0;
    logic [SCC_AW-1:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, r;
    logic pready_o, pslverr_o, e, card_hw_clock_i = 0, uart_tx_i = 0, tx_buf_moved_i = 0;
    logic card_present_i = 1, card_voltage_ok_i = 1, card_overcurrent_i = 0, seen;
    logic card_io_pin_i, aux_pin_four_i, aux_pin_eight_i, card_io_pin_o, card_io_pin_oe_o;
    logic aux_pin_four_o, aux_pin_four_oe_o, aux_pin_eight_o, aux_pin_eight_oe_o;
    logic card_clock_pin_o, card_reset_pin_o, card_supply_en_o, tx_data_valid_o, irq_o;
    logic [1:0] card_voltage_select_o, hc = 0;
    logic [7:0] tx_data_o;
    int err_count = 0, num_checks = 0;
    always #2 clk_i = ~clk_i;
    // Hardware card clock, eight system cycles a period
    always @(posedge clk_i) begin
        hc <= hc + 2'h1;
        if (hc == 2'h3) card_hw_clock_i <= ~card_hw_clock_i;
    end
    scc_contact dut (.*);
    scc_card_model card (.*);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Bus transfer; request held until ready is sampled high
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= {idx, 2'b00};
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        // No cycle limit here; only the watchdog ends a hung wait
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask
    task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        xfer(0, idx, 0);
        chk(nm, {24'h0, exp}, r);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask
    task automatic moved();
        @(posedge clk_i);
        tx_buf_moved_i <= 1;
        @(posedge clk_i);
        tx_buf_moved_i <= 0;
        settle();
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        err_count++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1;
        rd("contact reset", SCC_IDX_CONTACT, 8'h00);
        rd("status reset", SCC_IDX_STATUS, 8'hD0);
        xfer(1, SCC_IDX_CONTACT, 32'h07);
        settle();
        chk("reset pin", 1, card_reset_pin_o);
        chk("sw clock", 1, card_clock_pin_o);
        chk("supply", 1, card_supply_en_o);
        // Card holds I/O low while contact bits 0 to 5 are set
        xfer(1, SCC_IDX_CONTACT, 32'h3F);
        pull_low <= 1;
        settle();
        rd("io readback", SCC_IDX_CONTACT, 8'h37);
        chk("aux four oe", 0, aux_pin_four_oe_o);
        chk("aux eight oe", 0, aux_pin_eight_oe_o);
        chk("aux four level", 1, aux_pin_four_o);
        pull_low <= 0;
        xfer(1, SCC_IDX_CONTACT, 32'h7E);
        settle();
        chk("off reset pin", 0, card_reset_pin_o);
        rd("reserved bit", SCC_IDX_CONTACT, 8'h06);
        xfer(1, SCC_IDX_CONTACT, 32'h81);
        seen = 0;
        repeat (40) begin
            @(posedge clk_i);
            seen = seen | card_clock_pin_o;
        end
        chk("hw clock", 1, seen);
        xfer(1, SCC_IDX_CONTACT, 32'h01);
        repeat (20) @(posedge clk_i);
        chk("back to sw", 0, card_clock_pin_o);
        // Card I/O handed to the UART line
        xfer(1, SCC_IDX_CTRL, 32'h28);
        xfer(1, SCC_IDX_CONTACT, 32'h09);
        settle();
        chk("uart low", 1, card_io_pin_oe_o);
        chk("voltage select", 2, card_voltage_select_o);
        uart_tx_i <= 1;
        settle();
        chk("uart high", 0, card_io_pin_oe_o);
        chk("io level", 1, card_io_pin_o);
        xfer(1, SCC_IDX_CTRL, 32'h00);
        // Transmit empty flag and its interrupt
        xfer(1, SCC_IDX_IRQ_MASK, 32'h01);
        xfer(1, SCC_IDX_TXBUF, 32'h5A);
        @(posedge clk_i);
        chk("tx valid", 1, tx_data_valid_o);
        @(posedge clk_i);
        chk("tx valid drop", 0, tx_data_valid_o);
        settle();
        chk("tx data", 8'h5A, tx_data_o);
        rd("tbe cleared", SCC_IDX_STATUS, 8'h50);
        moved();
        chk("irq set", 1, irq_o);
        rd("tbe set", SCC_IDX_STATUS, 8'hD0);
        xfer(1, SCC_IDX_IRQ_STAT, 32'h01);
        settle();
        chk("irq cleared", 0, irq_o);
        xfer(1, SCC_IDX_IRQ_MASK, 32'h00);
        moved();
        chk("irq masked", 0, irq_o);
        card_voltage_ok_i <= 0;
        settle();
        rd("voltage bad", SCC_IDX_STATUS, 8'hC0);
        rd("irq status", SCC_IDX_IRQ_STAT, 8'h03);
        card_voltage_ok_i <= 1;
        card_present_i <= 0;
        settle();
        rd("card absent", SCC_IDX_STATUS, 8'h90);
        card_overcurrent_i <= 1;
        settle();
        rd("overcurrent", SCC_IDX_STATUS, 8'hB0);
        rd("irq ovf", SCC_IDX_IRQ_STAT, 8'h07);
        card_overcurrent_i <= 0;
        // Soft reset wipes the contacts
        xfer(1, SCC_IDX_CONTACT, 32'h03);
        xfer(1, SCC_IDX_CTRL, 32'h80);
        settle();
        chk("soft off", 0, card_supply_en_o);
        xfer(1, SCC_IDX_CTRL, 32'h00);
        rd("soft cleared", SCC_IDX_CONTACT, 8'h00);
        xfer(0, 8'hB2, 0);
        chk("unmapped", 1, e);
        summarize();
    end
endmodule
